// ### rtl/cfh_consts.vh
`ifndef CFH_CONSTS_VH
`define CFH_CONSTS_VH
// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define CFH_MAG_W        20
`define CFH_AC_W         21
`define CFH_MD_W         22
`define CFH_IM_W         20
`define CFH_ADDR_W       12
`define CFH_TIMER_W      14
`define CFH_NFLAG        10
`define CFH_NPREC        5
// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define CFH_MAX_MAG      20'hfffff
`define CFH_ADDR_MAX     12'hfff
// ----------------------------------------------------------------
// Flag positions
// ----------------------------------------------------------------
`define CFH_F_ADDOV      0
`define CFH_F_DIVOV      1
`define CFH_F_SHLOV      2
`define CFH_F_UNDEF      3
`define CFH_F_AUXADR     4
`define CFH_F_NMPAR      5
`define CFH_F_IMPAR      6
`define CFH_F_DIVTRB     7
`define CFH_F_RAROV      8
`define CFH_F_PHALT      9
// ----------------------------------------------------------------
// Overflow kinds
// ----------------------------------------------------------------
`define CFH_OV_NONE      2'h0
`define CFH_OV_ADD       2'h1
`define CFH_OV_SHL       2'h2
`endif

// ### rtl/cfh_console.v
`include "cfh_consts.vh"

module cfh_console (
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Processor events, same clock
    input  wire        instr_done,
    input  wire        overflow_branch_instr,
    input  wire        programmed_halt_instr,
    input  wire        add_overflow,
    input  wire        div_start,
    input  wire [20:0] dividend,
    input  wire [20:0] divisor,
    input  wire        div_overflow_instr,
    input  wire        shl_overflow,
    input  wire        undef_opcode,
    input  wire        aux_addr_error,
    input  wire        nm_parity_err,
    input  wire        im_parity_err,
    input  wire        div_trouble,
    input  wire        rel_add_valid,
    input  wire [11:0] rel_addr_a,
    input  wire [11:0] rel_addr_b,
    input  wire        single_order_mode,
    input  wire        program_rel_addr,
    input  wire        ac_load,
    input  wire [20:0] ac_in,
    input  wire [21:0] md_reg,
    input  wire [21:0] xfer_reg,
    input  wire [20:0] aux_div_reg,
    input  wire [19:0] im_rdata,
    input  wire [21:0] nm_rdata,
    // Console switches, asynchronous
    input  wire [2:0]  trunc_sw,
    input  wire [4:0]  prec_sw,
    input  wire [9:0]  ack_sw,
    input  wire [3:0]  stop_fault_sw,
    input  wire        phalt_enable_sw,
    input  wire        slow_mode_sw,
    input  wire        halt_on_overflow_switch,
    input  wire        aux_readout_sw,
    input  wire [11:0] addr_sw,
    input  wire        clear_tally_reladdr_control,
    input  wire        set_tally_sw,
    input  wire        set_reladdr_sw,
    input  wire        use_reladdr_sw,
    input  wire [11:0] seq_sw,
    input  wire        seq_reset_sw,
    input  wire [13:0] timer_sw,
    input  wire        timer_reset_sw,
    input  wire [11:0] mem_addr_sw,
    input  wire [21:0] mem_data_sw,
    input  wire        memory_select_switch,
    input  wire        mem_write_sw,
    input  wire        manual_oper_sw,
    // Lamps and processor controls
    output reg  [9:0]  flag_lamps,
    output reg         halted,
    output reg  [20:0] ac_lamps,
    output reg  [21:0] md_lamps,
    output reg  [21:0] xfer_lamps,
    output reg  [19:0] im_lamps,
    output reg  [11:0] tally_out,
    output reg  [11:0] reladdr_out,
    output reg  [11:0] rel_sum_out,
    output reg         force_rel_addr,
    output reg  [11:0] seq_out,
    output reg  [13:0] timer_out,
    output reg         mem_req,
    output reg         mem_is_nm,
    output reg         mem_we,
    output reg  [11:0] mem_addr,
    output reg  [21:0] mem_wdata
);

// ----------------------------------------------------------------
// Switch synchronisers
// ----------------------------------------------------------------
localparam SW_W = 3 + 5 + 10 + 4 + 5 + 12 + 4 + 12 + 1 + 14 + 1
                  + 12 + 22 + 3;
wire [SW_W-1:0] sw_raw = {trunc_sw, prec_sw, ack_sw, stop_fault_sw,
    phalt_enable_sw, slow_mode_sw, halt_on_overflow_switch,
    aux_readout_sw, use_reladdr_sw, addr_sw,
    clear_tally_reladdr_control, set_tally_sw, set_reladdr_sw,
    seq_reset_sw, seq_sw, timer_reset_sw, timer_sw, manual_oper_sw,
    mem_addr_sw, mem_data_sw, memory_select_switch, mem_write_sw,
    1'b0};
// Metastable, settled and delayed copies
reg  [SW_W-1:0] sw_meta_reg;
reg  [SW_W-1:0] sw_reg;
reg  [SW_W-1:0] sw_old_reg;

// Two flops, then a copy for edge detection
always @(posedge clk) begin
    if (srst) begin
        sw_meta_reg <= {SW_W{1'b0}};
        sw_reg      <= {SW_W{1'b0}};
        sw_old_reg  <= {SW_W{1'b0}};
    end else begin
        sw_meta_reg <= sw_raw;
        sw_reg      <= sw_meta_reg;
        sw_old_reg  <= sw_reg;
    end
end

wire [SW_W-1:0] sw_rise = sw_reg & ~sw_old_reg;

// Field positions in the packed switch word
localparam P_TRUNC = SW_W - 1;
localparam P_PREC  = P_TRUNC - 3;
localparam P_ACK   = P_PREC - `CFH_NPREC;
localparam P_STOP  = P_ACK - `CFH_NFLAG;
localparam P_PHEN  = P_STOP - 4;
localparam P_SLOW  = P_PHEN - 1;
localparam P_HOV   = P_SLOW - 1;
localparam P_AUXRO = P_HOV - 1;
localparam P_UREL  = P_AUXRO - 1;
localparam P_ADDR  = P_UREL - 1;
localparam P_CLR   = P_ADDR - `CFH_ADDR_W;
localparam P_STAL  = P_CLR - 1;
localparam P_SRAR  = P_STAL - 1;
localparam P_SQRS  = P_SRAR - 1;
localparam P_SEQ   = P_SQRS - 1;
localparam P_TMRS  = P_SEQ - `CFH_ADDR_W;
localparam P_TIMER = P_TMRS - 1;
localparam P_MAN   = P_TIMER - `CFH_TIMER_W;
localparam P_MADDR = P_MAN - 1;
localparam P_MDATA = P_MADDR - `CFH_ADDR_W;
localparam P_MSEL  = P_MDATA - `CFH_MD_W;
localparam P_MWR   = P_MSEL - 1;

// Unpack synchronised switches
wire [2:0]  s_trunc  = sw_reg[P_TRUNC -: 3];
wire [4:0]  s_prec   = sw_reg[P_PREC -: 5];
wire [9:0]  ack_p    = sw_rise[P_ACK -: 10];
wire [3:0]  s_stop   = sw_reg[P_STOP -: 4];
wire        s_phen   = sw_reg[P_PHEN];
wire        s_slow   = sw_reg[P_SLOW];
wire        s_hov    = sw_reg[P_HOV];
wire        s_auxro  = sw_reg[P_AUXRO];
wire        s_userel = sw_reg[P_UREL];
wire [11:0] s_addr   = sw_reg[P_ADDR -: 12];
wire        clr_p    = sw_rise[P_CLR];
wire        stal_p   = sw_rise[P_STAL];
wire        srar_p   = sw_rise[P_SRAR];
wire        sqrs_p   = sw_rise[P_SQRS];
wire [11:0] s_seq    = sw_reg[P_SEQ -: 12];
wire        tmrs_p   = sw_rise[P_TMRS];
wire [13:0] s_timer  = sw_reg[P_TIMER -: 14];
wire        man_p    = sw_rise[P_MAN];
wire [11:0] s_maddr  = sw_reg[P_MADDR -: 12];
wire [21:0] s_mdata  = sw_reg[P_MDATA -: 22];
wire        s_msel   = sw_reg[P_MSEL];
wire        s_mwr    = sw_reg[P_MWR];

// ----------------------------------------------------------------
// Accumulator conditioning
// ----------------------------------------------------------------
reg  [1:0]  pend_ov_reg;
reg         trunc_cond;
// Conditioned accumulator value
reg  [20:0] ac_mod;
wire [4:0]  prec_keep;
// Overflow kinds in truncate-switch order
wire [2:0]  ov_kind = {shl_overflow, div_overflow_instr, add_overflow};
wire [2:0]  trunc_hit;

// Per-bit precision mask on low stages
genvar gi;
generate
    for (gi = 0; gi < `CFH_NPREC; gi = gi + 1) begin : g_prec
        assign prec_keep[gi] = ~s_prec[gi];
    end
endgenerate

// Per-type truncation enables
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_trunc
        assign trunc_hit[gi] = ov_kind[gi] & s_trunc[gi];
    end
endgenerate

// Truncate on overflow, then precision suppress
always @* begin
    trunc_cond = |trunc_hit;
    ac_mod = ac_in;
    if (trunc_cond) begin
        ac_mod = {ac_in[`CFH_AC_W-1], `CFH_MAX_MAG};
    end
    ac_mod[`CFH_NPREC-1:0] = ac_mod[`CFH_NPREC-1:0] & prec_keep;
end

// ----------------------------------------------------------------
// Flags and halt
// ----------------------------------------------------------------
// Event decode results
reg  [9:0]  set_ev;
reg  [1:0]  pend_ov_next;
reg         inv_ov;
reg         halt_req_reg;
reg         halt_req_next;
// Thirteen-bit sum keeps the carry for the flag
wire [12:0] rel_sum = {1'b0, rel_addr_a} + {1'b0, rel_addr_b};

// Halt causes: faults, programmed halt, overflow
wire        halt_fault = (undef_opcode & s_stop[0])
                       | (aux_addr_error & s_stop[1])
                       | (nm_parity_err & s_stop[2])
                       | (im_parity_err & s_stop[3]);
wire        halt_prog  = programmed_halt_instr & s_phen;
wire        ov_halt_en = s_slow | s_hov;

// Event decode and overflow validity
always @* begin
    inv_ov = (pend_ov_reg != `CFH_OV_NONE) & instr_done
           & ~overflow_branch_instr;
    pend_ov_next = pend_ov_reg;
    if (instr_done) begin
        pend_ov_next = `CFH_OV_NONE;
    end
    if (add_overflow) begin
        pend_ov_next = `CFH_OV_ADD;
    end else if (shl_overflow) begin
        pend_ov_next = `CFH_OV_SHL;
    end
    set_ev = 10'h000;
    set_ev[`CFH_F_ADDOV]  = inv_ov & (pend_ov_reg == `CFH_OV_ADD);
    set_ev[`CFH_F_SHLOV]  = inv_ov & (pend_ov_reg == `CFH_OV_SHL);
    set_ev[`CFH_F_DIVOV]  = div_start & (dividend > divisor);
    set_ev[`CFH_F_UNDEF]  = undef_opcode;
    set_ev[`CFH_F_AUXADR] = aux_addr_error;
    set_ev[`CFH_F_NMPAR]  = nm_parity_err;
    set_ev[`CFH_F_IMPAR]  = im_parity_err;
    set_ev[`CFH_F_DIVTRB] = div_trouble;
    set_ev[`CFH_F_RAROV]  = rel_add_valid & rel_sum[`CFH_ADDR_W];
    set_ev[`CFH_F_PHALT]  = programmed_halt_instr;
    halt_req_next = halt_req_reg | halt_fault | halt_prog
        | ((set_ev[`CFH_F_DIVOV] | inv_ov) & ov_halt_en);
end

// Sticky flags, set beats acknowledge
always @(posedge clk) begin
    if (srst) begin
        flag_lamps   <= 10'h000;
        pend_ov_reg  <= `CFH_OV_NONE;
        halt_req_reg <= 1'b0;
        halted       <= 1'b0;
    end else begin
        flag_lamps  <= (flag_lamps & ~ack_p) | set_ev;
        pend_ov_reg <= pend_ov_next;
        // Halt lands at instruction end
        if (halt_req_next & instr_done) begin
            halted       <= 1'b1;
            halt_req_reg <= 1'b0;
        end else begin
            halt_req_reg <= halt_req_next;
        end
    end
end

// ----------------------------------------------------------------
// Displays
// ----------------------------------------------------------------
reg nm_shown_reg;

// Number word read out stays on the lamps until aux readout replaces it
always @(posedge clk) begin
    if (srst) begin
        ac_lamps     <= 21'h000000;
        md_lamps     <= 22'h000000;
        xfer_lamps   <= 22'h000000;
        nm_shown_reg <= 1'b0;
    end else begin
        if (ac_load) begin
            ac_lamps <= ac_mod;
        end
        xfer_lamps <= xfer_reg;
        if (mem_req & mem_is_nm & ~mem_we) begin
            md_lamps     <= nm_rdata;
            nm_shown_reg <= 1'b1;
        end else if (halted & s_auxro) begin
            md_lamps     <= {1'b0, aux_div_reg};
            nm_shown_reg <= 1'b0;
        end else if (halted & nm_shown_reg) begin
            md_lamps <= md_lamps;
        end else begin
            md_lamps <= md_reg;
        end
    end
end

// ----------------------------------------------------------------
// Manual loads and memory access
// ----------------------------------------------------------------
// Clear must come before each set
reg clr_armed_reg;

always @(posedge clk) begin
    if (srst) begin
        tally_out      <= 12'h000;
        reladdr_out    <= 12'h000;
        rel_sum_out    <= 12'h000;
        force_rel_addr <= 1'b0;
        clr_armed_reg  <= 1'b0;
        seq_out        <= 12'h000;
        timer_out      <= 14'h0000;
        mem_req        <= 1'b0;
        mem_is_nm      <= 1'b0;
        mem_we         <= 1'b0;
        mem_addr       <= 12'h000;
        mem_wdata      <= 22'h000000;
        im_lamps       <= 20'h00000;
    end else begin
        rel_sum_out <= rel_sum[`CFH_ADDR_W-1:0];
        force_rel_addr <= single_order_mode
                        & (s_userel | program_rel_addr);
        if (clr_p) begin
            tally_out     <= 12'h000;
            reladdr_out   <= 12'h000;
            clr_armed_reg <= 1'b1;
        end else if (stal_p & clr_armed_reg) begin
            tally_out     <= s_addr;
            clr_armed_reg <= 1'b0;
        end else if (srar_p & clr_armed_reg) begin
            reladdr_out   <= s_addr;
            clr_armed_reg <= 1'b0;
        end
        if (sqrs_p) begin
            seq_out <= s_seq;
        end
        if (tmrs_p) begin
            timer_out <= s_timer;
        end
        mem_req <= man_p & halted;
        if (man_p & halted) begin
            mem_is_nm <= s_msel;
            mem_we    <= s_mwr;
            mem_addr  <= s_maddr;
            mem_wdata <= s_msel ? s_mdata
                       : {2'h0, s_mdata[`CFH_IM_W-1:0]};
        end
        if (mem_req & ~mem_is_nm) begin
            im_lamps <= mem_we ? mem_wdata[`CFH_IM_W-1:0]
                               : im_rdata;
        end
    end
end

endmodule // cfh_console

// ### verif/cfh_console_asserts.sv
module cfh_console_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Processor events
    input wire logic        instr_done,
    input wire logic        overflow_branch_instr,
    input wire logic        add_overflow,
    input wire logic        shl_overflow,
    input wire logic        div_start,
    input wire logic [20:0] dividend,
    input wire logic [20:0] divisor,
    input wire logic        rel_add_valid,
    input wire logic [11:0] rel_addr_a,
    input wire logic [11:0] rel_addr_b,
    // Operator and lamps
    input wire logic [9:0]  ack_sw,
    input wire logic [9:0]  flag_lamps,
    input wire logic        halted,
    input wire logic        mem_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // Overflow followed by the next instruction's end
    // ------------------------------------------------------------
    sequence s_add_nobr;
        add_overflow ##1 (instr_done && !overflow_branch_instr);
    endsequence
    sequence s_add_br;
        add_overflow ##1 (instr_done && overflow_branch_instr);
    endsequence
    sequence s_shl_nobr;
        shl_overflow ##1 (instr_done && !overflow_branch_instr);
    endsequence
    a_add_ov_flag: assert property (s_add_nobr |=> flag_lamps[0])
        else $error("add overflow flag missing");
    a_branch_no_flag: assert property (
        s_add_br |=> !$rose(flag_lamps[0]))
        else $error("flag lit despite overflow branch");
    a_shl_ov_flag: assert property (s_shl_nobr |=> flag_lamps[2])
        else $error("shift overflow flag missing");
    a_div_ov_flag: assert property (
        div_start && !dividend[20] && !divisor[20] && dividend > divisor
        |=> flag_lamps[1])
        else $error("divide overflow flag missing");
    a_rar_flag: assert property (
        rel_add_valid && {1'b0, rel_addr_a} + {1'b0, rel_addr_b} > 13'h0fff
        |=> flag_lamps[8])
        else $error("address overflow flag missing");
    a_flag_stays: assert property (
        (flag_lamps[3] && !ack_sw[3]) [*5] |=> flag_lamps[3])
        else $error("flag dropped without acknowledge");
    a_halt_on_done: assert property ($rose(halted) |-> $past(instr_done))
        else $error("halt outside instruction end");
    a_mem_gate: assert property (mem_req |-> halted ##1 !mem_req)
        else $error("memory request while running or too long");
endmodule // cfh_console_chk

bind cfh_console cfh_console_chk u_chk (.*);

// ### verif/cfh_operator.sv
module cfh_operator (
    // Clock
    input  wire logic       clk,
    // Pushbuttons towards the console logic
    output wire logic [9:0] ack_sw,
    output wire logic       clear_tally_reladdr_control,
    output wire logic       set_tally_sw,
    output wire logic       set_reladdr_sw,
    output wire logic       seq_reset_sw,
    output wire logic       timer_reset_sw,
    output wire logic       manual_oper_sw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] btn_reg = 16'h0000;
    // Released buttons rest low
    assign {manual_oper_sw, timer_reset_sw, seq_reset_sw, set_reladdr_sw,
            set_tally_sw, clear_tally_reladdr_control, ack_sw} = btn_reg;
    // One press, held long enough to pass the synchroniser
    task automatic press(input int b, input int hold = 6);
        @(posedge clk);
        btn_reg[b] <= 1'b1;
        repeat (hold) @(posedge clk);
        btn_reg[b] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // cfh_operator

// ### verif/cfh_console_bench.sv
module cfh_console_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] DN = 14'h1, BR = 14'h2, PH = 14'h4,
        ADD = 14'h8, DIV = 14'h10, DVO = 14'h20, SHL = 14'h40, UND = 14'h80,
        AUX = 14'h100, NMP = 14'h200, IMP = 14'h400, DTR = 14'h800,
        RAV = 14'h1000, ACL = 14'h2000;
    // Clock, reset and processor event pulses
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [13:0] ev = 14'h0;
    wire instr_done = ev[0], overflow_branch_instr = ev[1],
        programmed_halt_instr = ev[2], add_overflow = ev[3],
        div_start = ev[4], div_overflow_instr = ev[5],
        shl_overflow = ev[6], undef_opcode = ev[7], aux_addr_error = ev[8],
        nm_parity_err = ev[9], im_parity_err = ev[10],
        div_trouble = ev[11], rel_add_valid = ev[12], ac_load = ev[13];
    // Processor levels and console switches
    logic [20:0] dividend = 21'h0, divisor = 21'h0, ac_in = 21'h0,
                 aux_div_reg = 21'h0;
    logic [21:0] md_reg = 22'h0, xfer_reg = 22'h0, nm_rdata = 22'h0,
                 mem_data_sw = 22'h0;
    logic [11:0] rel_addr_a = 12'h0, rel_addr_b = 12'h0, addr_sw = 12'h0,
                 seq_sw = 12'h0, mem_addr_sw = 12'h0;
    logic [19:0] im_rdata = 20'h0;
    logic [13:0] timer_sw = 14'h0;
    logic [4:0]  prec_sw = 5'h0;
    logic [3:0]  stop_fault_sw = 4'h0;
    logic [2:0]  trunc_sw = 3'h0;
    logic        single_order_mode = 0, program_rel_addr = 0,
                 phalt_enable_sw = 0, slow_mode_sw = 0, aux_readout_sw = 0,
                 halt_on_overflow_switch = 0, use_reladdr_sw = 0,
                 memory_select_switch = 0, mem_write_sw = 0;
    wire  [9:0]  ack_sw;
    wire         clear_tally_reladdr_control, set_tally_sw, set_reladdr_sw,
                 seq_reset_sw, timer_reset_sw, manual_oper_sw;
    // Lamps and processor controls
    logic [9:0]  flag_lamps;
    logic        halted, force_rel_addr, mem_req, mem_is_nm, mem_we;
    logic [20:0] ac_lamps;
    logic [21:0] md_lamps, xfer_lamps, mem_wdata;
    logic [19:0] im_lamps;
    logic [11:0] tally_out, reladdr_out, rel_sum_out, seq_out, mem_addr;
    logic [13:0] timer_out;
    int          failures = 0, checks_done = 0, nreq = 0;

    cfh_console dut (.*);
    cfh_operator op (.*);
    // Clock and memory request counter
    always #12.5 clk = ~clk;
    always @(posedge clk) if (mem_req) nreq <= nreq + 1;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    // Two event cycles back to back, then a short settle
    task automatic pulse(input logic [13:0] m1, input logic [13:0] m2);
        ev <= m1;
        @(posedge clk);
        ev <= m2;
        @(posedge clk);
        ev <= 14'h0;
        cyc(2);
    endtask
    task automatic rst();
        srst <= 1'b1;
        cyc(20);
        srst <= 1'b0;
        cyc(1);
    endtask
    task automatic t_faults();
        pulse(DN | PH | UND | AUX | NMP | IMP | DTR, 14'h0);
        chk(flag_lamps, 10'h2f8);
        chk(flag_lamps[8:4], 5'h0f);
        chk(halted, 1'b0);
        op.press(3);
        cyc(1);
        chk(flag_lamps, 10'h2f0);
        for (int i = 4; i < 10; i++) op.press(i);
        cyc(1);
        chk(flag_lamps, 10'h000);
    endtask
    task automatic t_overflow();
        pulse(ADD, DN | BR);
        chk(flag_lamps, 10'h000);
        pulse(ADD, DN);
        chk(flag_lamps, 10'h001);
        pulse(SHL, DN);
        chk(flag_lamps, 10'h005);
        dividend <= 21'h5;
        divisor <= 21'h3;
        pulse(DIV, 14'h0);
        chk(flag_lamps, 10'h007);
        rel_addr_a <= 12'hfff;
        rel_addr_b <= 12'h002;
        pulse(RAV, 14'h0);
        chk(flag_lamps, 10'h107);
        chk(rel_sum_out, 12'h001);
        chk(halted, 1'b0);
    endtask
    task automatic t_loads();
        addr_sw <= 12'h9c3;
        op.press(11);
        cyc(1);
        chk(tally_out, 12'h000);
        op.press(10);
        op.press(11);
        cyc(1);
        chk(tally_out, 12'h9c3);
        op.press(10);
        op.press(12);
        cyc(1);
        chk(reladdr_out, 12'h9c3);
        seq_sw <= 12'h5a3;
        timer_sw <= 14'h2c71;
        op.press(13);
        op.press(14);
        cyc(1);
        chk(seq_out, 12'h5a3);
        chk(timer_out, 14'h2c71);
        single_order_mode <= 1'b1;
        use_reladdr_sw <= 1'b1;
        md_reg <= 22'h2a5c3f;
        xfer_reg <= 22'h15a3c0;
        aux_readout_sw <= 1'b1;
        prec_sw <= 5'h1f;
        ac_in <= 21'h1fffff;
        cyc(5);
        chk(force_rel_addr, 1'b1);
        pulse(ACL, 14'h0);
        chk(ac_lamps, 21'h1fffe0);
        chk(md_lamps, 22'h2a5c3f);
        chk(xfer_lamps, 22'h15a3c0);
    endtask
    task automatic t_manual();
        stop_fault_sw <= 4'h1;
        mem_addr_sw <= 12'h7e1;
        mem_data_sw <= 22'h3abcde;
        mem_write_sw <= 1'b1;
        aux_div_reg <= 21'h1f0f0f;
        op.press(15);
        chk(nreq, 0);
        pulse(UND, DN);
        chk(halted, 1'b1);
        op.press(15);
        cyc(1);
        chk(nreq, 1);
        chk({mem_is_nm, mem_we, mem_addr}, {2'b01, 12'h7e1});
        chk(mem_wdata, 22'h0abcde);
        chk(im_lamps, 20'habcde);
        chk(md_lamps, 22'h1f0f0f);
        aux_readout_sw <= 1'b0;
        memory_select_switch <= 1'b1;
        mem_write_sw <= 1'b0;
        nm_rdata <= 22'h155aa5;
        cyc(5);
        op.press(15);
        cyc(1);
        chk({nreq[1:0], mem_is_nm, mem_we}, 4'ha);
        chk(md_lamps, 22'h155aa5);
        memory_select_switch <= 1'b0;
        im_rdata <= 20'h5a5a5;
        cyc(5);
        op.press(15);
        cyc(1);
        chk(im_lamps, 20'h5a5a5);
        chk(md_lamps, 22'h155aa5);
    endtask
    task automatic t_extra();
        prec_sw <= 5'h0;
        trunc_sw <= 3'h7;
        ac_in <= 21'h012345;
        cyc(5);
        pulse(ADD | ACL, DN | BR);
        chk(ac_lamps, 21'h0fffff);
        ac_in <= 21'h112345;
        pulse(DVO | ACL, 14'h0);
        chk(ac_lamps, 21'h1fffff);
        trunc_sw <= 3'h3;
        cyc(5);
        pulse(SHL | ACL, DN | BR);
        chk(ac_lamps, 21'h112345);
        chk(flag_lamps, 10'h000);
        single_order_mode <= 1'b1;
        use_reladdr_sw <= 1'b0;
        program_rel_addr <= 1'b1;
        cyc(5);
        chk(force_rel_addr, 1'b1);
        program_rel_addr <= 1'b0;
        cyc(2);
        chk(force_rel_addr, 1'b0);
        halt_on_overflow_switch <= 1'b1;
        cyc(5);
        pulse(SHL, DN);
        chk({halted, flag_lamps}, 11'h404);
        rst();
        halt_on_overflow_switch <= 1'b0;
        phalt_enable_sw <= 1'b1;
        cyc(5);
        pulse(PH, DN);
        chk({halted, flag_lamps}, 11'h600);
    endtask
    task automatic t_slow();
        slow_mode_sw <= 1'b1;
        cyc(5);
        pulse(ADD, DN);
        chk(halted, 1'b1);
        pulse(DN, 14'h0);
        chk(halted, 1'b1);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        cyc(20);
        srst <= 1'b0;
        cyc(1);
        t_faults();
        t_overflow();
        rst();
        t_loads();
        rst();
        t_manual();
        rst();
        t_extra();
        rst();
        t_slow();
        print_verdict();
    end
    // Watchdog, several times the expected run of about 450 cycles
    initial begin
        #100us;
        failures++;
        print_verdict();
    end
endmodule // cfh_console_bench
